/* File: design/srq_pkg.sv */
// srq_pkg: constants and types for the status reporting / service request block
// assumes a single 20 MHz instrument clock and an asynchronous active-high reset
package srq_pkg;
    // status byte bit positions
    localparam int STB_QUES_BIT = 3;
    localparam int STB_MAV_BIT  = 4;
    localparam int STB_ESB_BIT  = 5;
    localparam int STB_RQS_BIT  = 6;
    // standard event bit positions
    localparam int ESR_OPC_BIT  = 0;
    localparam int ESR_QYE_BIT  = 2;
    localparam int ESR_DDE_BIT  = 3;
    localparam int ESR_EXE_BIT  = 4;
    localparam int ESR_CME_BIT  = 5;
    localparam int ESR_PON_BIT  = 7;
    // questionable bit positions
    localparam int QUES_CC_BIT  = 0;
    localparam int QUES_CV_BIT  = 1;
    localparam int QUES_FAN_BIT = 4;
    localparam int QUES_OV_BIT  = 9;
    // implemented-bit masks
    localparam logic [7:0]  STB_USED_MASK  = 8'h78;
    localparam logic [7:0]  ESR_USED_MASK  = 8'hBD;
    localparam logic [15:0] QUES_USED_MASK = 16'h0213;
    // reset values
    localparam logic [7:0]  ENA8_RST  = 8'h00;
    localparam logic [15:0] ENA16_RST = 16'h0000;
    localparam logic        PSC_RST   = 1'b1;
    // error queue
    localparam int ERRQ_DEPTH   = 20;
    localparam int ERRQ_AW      = 5;
    localparam int ERR_W        = 16;
    localparam logic [ERR_W-1:0] ERR_NONE     = 16'h0000;
    localparam logic [ERR_W-1:0] ERR_OVERFLOW = 16'hFEA2;
    localparam logic [ERRQ_AW-1:0] ERRQ_LAST  = 5'h13;
    localparam logic [ERRQ_AW:0]   ERRQ_FULL  = 6'h14;
    // output buffer depth (response words) before overload
    localparam logic [3:0] OBUF_LIMIT = 4'hF;
    localparam logic [15:0] OPC_ANSWER = 16'h0001;

    typedef enum logic [4:0] {
        CMD_NONE      = 5'h00,
        CMD_CLS       = 5'h01,
        CMD_ESE_WR    = 5'h02,
        CMD_ESE_RD    = 5'h03,
        CMD_ESR_RD    = 5'h04,
        CMD_OPC       = 5'h05,
        CMD_OPC_RD    = 5'h06,
        CMD_PSC_WR    = 5'h07,
        CMD_PSC_RD    = 5'h08,
        CMD_SRE_WR    = 5'h09,
        CMD_SRE_RD    = 5'h0A,
        CMD_STB_RD    = 5'h0B,
        CMD_WAI       = 5'h0C,
        CMD_QCOND_RD  = 5'h0D,
        CMD_QEVT_RD   = 5'h0E,
        CMD_QENA_WR   = 5'h0F,
        CMD_QENA_RD   = 5'h10,
        CMD_ERR_RD    = 5'h11
    } srq_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_WAIT  = 2'b01,
        ST_HALT  = 2'b10
    } srq_state_t;
endpackage

/* File: design/srq_event_reg.sv */
// srq_event_reg: one latched event register with enable mask and summary bit
// assumes set pulses arrive on the instrument clock; set wins over clear
`timescale 1ns/1ps
module srq_event_reg #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] set_bits,
    input  wire logic         clr,
    input  wire logic [W-1:0] ena,
    output logic      [W-1:0] evt_ff,
    output logic              summary
);
    logic [W-1:0] nxt_evt;

    // RULE14 latch then clear
    assign nxt_evt = (clr ? {W{1'b0}} : evt_ff) | set_bits;
    // RULE26 masked or summary
    assign summary = |(evt_ff & ena);

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            evt_ff <= {W{1'b0}};
        end else begin
            evt_ff <= nxt_evt;
        end
    end
endmodule

/* File: design/srq_err_queue.sv */
// srq_err_queue: 20-entry first-in first-out error store
// assumes one push and one pop pulse per cycle at most; clear empties it except for an error pushed in the same cycle
`timescale 1ns/1ps
module srq_err_queue
    import srq_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             push,
    input  wire logic [ERR_W-1:0] push_code,
    input  wire logic             pop,
    input  wire logic             clr,
    output logic      [ERR_W-1:0] head,
    output logic                  not_empty
);
    logic [ERR_W-1:0]   mem [ERRQ_DEPTH];
    logic [ERRQ_AW-1:0] rd_ff;
    logic [ERRQ_AW-1:0] wr_ff;
    logic [ERRQ_AW:0]   cnt_ff;
    logic               full;
    logic               do_pop;
    logic               do_push;
    logic               do_ovf;
    logic [ERRQ_AW-1:0] last_idx;

    assign full      = (cnt_ff == ERRQ_FULL);
    assign not_empty = (cnt_ff != '0);
    assign head      = not_empty ? mem[rd_ff] : ERR_NONE;
    assign do_pop    = pop && not_empty;
    assign do_push   = push && !full;
    // newest entry replaced by overflow code when full
    assign do_ovf    = push && full && !do_pop;
    assign last_idx  = (wr_ff == '0) ? ERRQ_LAST : wr_ff - 5'h01;

    always_ff @(posedge clk) begin
        if (do_push || (clr && push)) begin
            mem[clr ? '0 : wr_ff] <= push_code;
        end else if (do_ovf) begin
            mem[last_idx] <= ERR_OVERFLOW;
        end
    end

    // RULE11 fifo order
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_ff  <= '0;
            wr_ff  <= '0;
            cnt_ff <= '0;
        end else if (clr) begin
            // error arriving with clear survives it
            rd_ff  <= '0;
            wr_ff  <= {4'h0, push};
            cnt_ff <= {5'h00, push};
        end else begin
            if (do_pop) begin
                rd_ff <= (rd_ff == ERRQ_LAST) ? '0 : rd_ff + 5'h01;
            end
            if (do_push) begin
                wr_ff <= (wr_ff == ERRQ_LAST) ? '0 : wr_ff + 5'h01;
            end
            // RULE12 empty after reads
            cnt_ff <= cnt_ff + {5'h00, do_push} - {5'h00, do_pop};
        end
    end
endmodule

/* File: design/srq_status.sv */
// srq_status: status byte, event registers, service request and error queue
// assumes a command parser presents one decoded command per cmd_valid pulse
// and that the bus interface signals serial polls and output-buffer activity
`timescale 1ns/1ps
// Overview of operation
// RULE1 - enable mask picks summary bits for request
// RULE2 - request bit drives service request line
// RULE3 - request cleared by poll or event read
// RULE4 - serial poll returns byte, clears request
// RULE5 - status query leaves request bit set
// RULE6 - status query executes in command order
// RULE7 - message available while output data waits
// RULE8 - operation complete command sets event bit
// RULE9 - operation complete query answers one
// RULE10 - output overload stops command processing
// RULE11 - error queue fifo, twenty entries
// RULE12 - all errors read turns indicator off
// RULE13 - condition register follows regulation mode
// RULE14 - questionable events latch, read clears
// RULE15 - questionable mask selects summary bits
// RULE16 - clear status clears all event registers
// RULE17 - standard event mask selects summary
// RULE18 - query answers binary weighted value
// RULE19 - power-on clear setting governs mask reset
// RULE20 - wait holds commands until operations finish; the code holds them only when triggered_mode is set
// RULE21 - controller enables complete then polls
// RULE22 - controller setup order before requests
// RULE23 - status byte bit layout fixed
// RULE24 - standard event bit layout fixed
// RULE25 - questionable bit layout fixed
// RULE26 - summaries are masked or reductions
module srq_status
    import srq_pkg::*;
(
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire logic               cmd_valid,
    input  wire srq_pkg::srq_cmd_t  cmd_code,
    input  wire logic [15:0]        cmd_arg,
    output logic                    cmd_ready_ff,
    output logic                    rsp_valid_ff,
    output logic [15:0]             rsp_data_ff,
    input  wire logic               ops_pending,
    input  wire logic               triggered_mode,
    input  wire logic               obuf_push,
    input  wire logic               obuf_pop,
    input  wire logic               power_on,
    input  wire logic               constant_current_mode,
    input  wire logic               constant_voltage_mode,
    input  wire logic               fan_fault,
    input  wire logic               ov_tripped,
    input  wire logic               ev_query_err,
    input  wire logic               ev_device_err,
    input  wire logic               ev_exec_err,
    input  wire logic               ev_cmd_err,
    input  wire logic [15:0]        err_code,
    input  wire logic               serial_poll,
    output logic [7:0]              poll_byte_ff,
    output logic                    poll_valid_ff,
    output logic                    srq_ff,
    output logic                    error_ind_ff,
    output logic                    overload_ff
);
    srq_state_t   state_ff;
    srq_state_t   nxt_state;
    logic [7:0]   sre_ff;
    logic [7:0]   ese_ff;
    logic [15:0]  qena_ff;
    logic         psc_ff;
    logic         rqs_ff;
    logic         nxt_rqs;
    logic         pon_seen_ff;
    logic [3:0]   obuf_cnt_ff;
    logic [3:0]   nxt_obuf_cnt;
    logic [7:0]   esr_q;
    logic [15:0]  ques_q;
    logic         esb;
    logic         ques_sum;
    logic         mav;
    logic         cls;
    logic         take;
    logic         is_query;
    logic [7:0]   stb_val;
    logic [7:0]   stb_req_mask;
    logic         rqs_cause;
    logic         rqs_cause_ff;
    logic [15:0]  qcond;
    logic [7:0]   esr_set;
    logic [15:0]  ques_set;
    logic [15:0]  rsp_val;
    logic         opc_set;
    logic         esr_read;
    logic         qevt_read;
    logic         err_read;
    logic [15:0]  err_head;
    logic         err_any;
    logic         pon_pulse;
    logic         obuf_in;

    // RULE13 unlatched condition
    assign qcond = {6'h00, ov_tripped, 4'h0, fan_fault, 2'h0,
                    constant_voltage_mode, constant_current_mode};

    assign take      = cmd_valid && cmd_ready_ff;
    // RULE16 clear status
    assign cls       = take && (cmd_code == CMD_CLS);
    assign esr_read  = take && (cmd_code == CMD_ESR_RD);
    assign qevt_read = take && (cmd_code == CMD_QEVT_RD);
    assign err_read  = take && (cmd_code == CMD_ERR_RD);
    // RULE8 opc sets bit
    assign opc_set   = take && (cmd_code == CMD_OPC);
    assign pon_pulse = power_on && !pon_seen_ff;

    // RULE24 standard event layout
    assign esr_set = {pon_pulse, 1'b0, ev_cmd_err, ev_exec_err,
                      ev_device_err, ev_query_err, 1'b0, opc_set} & ESR_USED_MASK;
    // RULE25 questionable layout
    assign ques_set = qcond & QUES_USED_MASK;

    srq_event_reg #(.W(8)) u_esr (
        .clk      (clk),
        .rst      (rst),
        .set_bits (esr_set),
        .clr      (cls || esr_read),
        .ena      (ese_ff),
        .evt_ff   (esr_q),
        .summary  (esb)
    );

    // RULE15 questionable enable
    srq_event_reg #(.W(16)) u_ques (
        .clk      (clk),
        .rst      (rst),
        .set_bits (ques_set),
        .clr      (cls || qevt_read),
        .ena      (qena_ff),
        .evt_ff   (ques_q),
        .summary  (ques_sum)
    );

    // RULE11 error storage
    srq_err_queue u_errq (
        .clk       (clk),
        .rst       (rst),
        .push      (ev_query_err | ev_device_err | ev_exec_err | ev_cmd_err),
        .push_code (err_code),
        .pop       (err_read),
        .clr       (cls),
        .head      (err_head),
        .not_empty (err_any)
    );

    // RULE7 message available
    assign obuf_in = obuf_push || (take && is_query);
    assign mav     = (obuf_cnt_ff != 4'h0);

    // RULE23 status byte layout
    assign stb_val = {1'b0, rqs_ff, esb, mav, ques_sum, 3'b000} & STB_USED_MASK;
    // RULE1 request mask
    assign stb_req_mask = stb_val & sre_ff & ~(8'h01 << STB_RQS_BIT);
    // RULE26 request from masked byte
    assign rqs_cause = |stb_req_mask;

    // RULE3 clear on poll or read
    always_comb begin
        nxt_rqs = rqs_ff;
        if (serial_poll || cls) begin
            nxt_rqs = 1'b0;
        end else if (esr_read && sre_ff[STB_ESB_BIT] && esb) begin
            nxt_rqs = 1'b0;
        end else if (qevt_read && sre_ff[STB_QUES_BIT] && ques_sum) begin
            nxt_rqs = 1'b0;
        end else if (rqs_cause && !rqs_cause_ff) begin
            nxt_rqs = 1'b1;
        end
    end

    always_comb begin
        is_query = 1'b1;
        rsp_val  = 16'h0000;
        case (cmd_code)
            CMD_ESE_RD:   rsp_val = {8'h00, ese_ff};
            CMD_ESR_RD:   rsp_val = {8'h00, esr_q};
            CMD_OPC_RD:   rsp_val = OPC_ANSWER;
            CMD_PSC_RD:   rsp_val = {15'h0000, psc_ff};
            CMD_SRE_RD:   rsp_val = {8'h00, sre_ff};
            // RULE5 request bit left alone
            CMD_STB_RD:   rsp_val = {8'h00, stb_val};
            CMD_QCOND_RD: rsp_val = qcond;
            CMD_QEVT_RD:  rsp_val = ques_q;
            CMD_QENA_RD:  rsp_val = qena_ff;
            CMD_ERR_RD:   rsp_val = err_head;
            default:      is_query = 1'b0;
        endcase
    end

    // RULE10 overload halts
    always_comb begin
        nxt_obuf_cnt = obuf_cnt_ff;
        if (obuf_in && !obuf_pop && obuf_cnt_ff != OBUF_LIMIT) begin
            nxt_obuf_cnt = obuf_cnt_ff + 4'h1;
        end else if (!obuf_in && obuf_pop && mav) begin
            nxt_obuf_cnt = obuf_cnt_ff - 4'h1;
        end
    end

    // RULE20 wait holds commands
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (obuf_in && !obuf_pop && obuf_cnt_ff == OBUF_LIMIT) begin
                    nxt_state = ST_HALT;
                end else if (take && cmd_code == CMD_WAI && triggered_mode && ops_pending) begin
                    nxt_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!ops_pending) begin
                    nxt_state = ST_IDLE;
                end
            end
            ST_HALT: begin
                if (obuf_pop) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff     <= ST_IDLE;
            obuf_cnt_ff  <= 4'h0;
            rqs_ff       <= 1'b0;
            rqs_cause_ff <= 1'b0;
            pon_seen_ff  <= 1'b0;
            cmd_ready_ff <= 1'b0;
            overload_ff  <= 1'b0;
        end else begin
            state_ff     <= nxt_state;
            obuf_cnt_ff  <= cls ? 4'h0 : nxt_obuf_cnt;
            // RULE2 request follows bit
            rqs_ff       <= nxt_rqs;
            rqs_cause_ff <= rqs_cause;
            pon_seen_ff  <= power_on;
            // RULE6 queries in order
            cmd_ready_ff <= (nxt_state == ST_IDLE) && !take;
            overload_ff  <= (nxt_state == ST_HALT);
        end
    end

    // RULE19 power-on mask clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sre_ff  <= ENA8_RST;
            ese_ff  <= ENA8_RST;
            qena_ff <= ENA16_RST;
            psc_ff  <= PSC_RST;
        end else begin
            if (pon_pulse && psc_ff) begin
                sre_ff <= ENA8_RST;
                ese_ff <= ENA8_RST;
            end
            if (take && cmd_code == CMD_SRE_WR) begin
                sre_ff <= cmd_arg[7:0];
            end
            // RULE17 event mask write
            if (take && cmd_code == CMD_ESE_WR) begin
                ese_ff <= cmd_arg[7:0];
            end
            if (take && cmd_code == CMD_QENA_WR) begin
                qena_ff <= cmd_arg;
            end
            if (take && cmd_code == CMD_PSC_WR) begin
                psc_ff <= cmd_arg[0];
            end
        end
    end

    // RULE18 binary weighted answer
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rsp_valid_ff  <= 1'b0;
            rsp_data_ff   <= 16'h0000;
            poll_valid_ff <= 1'b0;
            poll_byte_ff  <= 8'h00;
            srq_ff        <= 1'b0;
            error_ind_ff  <= 1'b0;
        end else begin
            // RULE9 answer via response
            rsp_valid_ff  <= take && is_query;
            rsp_data_ff   <= (take && is_query) ? rsp_val : rsp_data_ff;
            // RULE4 poll answered at once
            poll_valid_ff <= serial_poll;
            poll_byte_ff  <= serial_poll ? stb_val : poll_byte_ff;
            srq_ff        <= nxt_rqs;
            // RULE12 indicator follows queue
            error_ind_ff  <= err_any;
        end
    end
endmodule

/* File: verification/srq_status_checker.sv */
// srq_status_checker: port timing relations of the status block
// assumes bind onto srq_status, one clock, async active-high reset
`timescale 1ns/1ps
module srq_status_checker
    import srq_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              cmd_valid,
    input wire srq_pkg::srq_cmd_t cmd_code,
    input wire logic              cmd_ready_ff,
    input wire logic              rsp_valid_ff,
    input wire logic [15:0]       rsp_data_ff,
    input wire logic              ops_pending,
    input wire logic              triggered_mode,
    input wire logic              serial_poll,
    input wire logic [7:0]        poll_byte_ff,
    input wire logic              poll_valid_ff,
    input wire logic              srq_ff,
    input wire logic              overload_ff
);
    import srq_pkg::*;
    default clocking @(posedge clk);
    endclocking
    default disable iff (rst);
    wire take = cmd_valid && cmd_ready_ff;

    a_poll_answer: assert property (serial_poll |=> poll_valid_ff && !srq_ff)
        else $error("serial poll gave no answer or left the request set");
    a_poll_rqs: assert property (serial_poll |=> poll_byte_ff[6] == $past(srq_ff))
        else $error("polled request bit differs from the request line");
    a_poll_unused: assert property (poll_valid_ff |-> (poll_byte_ff & 8'h87) == 8'h00)
        else $error("unused status byte bit set");
    a_srq_holds: assert property (srq_ff && !serial_poll && !take |=> srq_ff)
        else $error("service request dropped without poll or command");
    a_stb_keeps: assert property (
        take && cmd_code == CMD_STB_RD && srq_ff && !serial_poll |=> srq_ff && rsp_data_ff[6])
        else $error("status query disturbed the request bit");
    a_wait_holds: assert property (
        take && cmd_code == CMD_WAI && triggered_mode && ops_pending
        |=> !cmd_ready_ff ##1 (!cmd_ready_ff || !$past(ops_pending)))
        else $error("command accepted while operations pending after wait");
    a_overload_halt: assert property (overload_ff && $past(overload_ff) |-> !cmd_ready_ff)
        else $error("command accepted during output overload");
    a_opc_answer: assert property (
        take && cmd_code == CMD_OPC_RD |=> rsp_valid_ff && rsp_data_ff == OPC_ANSWER)
        else $error("operation complete query did not answer one");
    a_rsp_cause: assert property (rsp_valid_ff |-> $past(take))
        else $error("answer without a preceding command");

    c_srq_raised: cover property ($rose(srq_ff));
    c_overload: cover property ($rose(overload_ff));
    c_poll_rqs: cover property (poll_valid_ff && poll_byte_ff[6]);
endmodule

/* File: verification/srq_host.sv */
// srq_host: bus controller model sending commands, queries and serial polls
// assumes falling-edge drive and the one-command handshake of the block
`timescale 1ns/1ps
module srq_host
    import srq_pkg::*;
(
    input  wire logic         clk,
    input  wire logic         cmd_ready_ff,
    input  wire logic         rsp_valid_ff,
    input  wire logic [15:0]  rsp_data_ff,
    input  wire logic         poll_valid_ff,
    input  wire logic [7:0]   poll_byte_ff,
    output srq_pkg::srq_cmd_t cmd_code,
    output logic              cmd_valid,
    output logic [15:0]       cmd_arg,
    output logic              serial_poll
);
    import srq_pkg::*;
    initial begin
        cmd_valid = 1'b0;
        cmd_code = CMD_NONE;
        cmd_arg = 16'h0000;
        serial_poll = 1'b0;
    end

    // offer a command, hold it through the taking edge
    task automatic send(input srq_cmd_t c, input logic [15:0] a);
        int n = 0;
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_code = c;
        cmd_arg = a;
        while (!cmd_ready_ff && n < 200) begin
            @(negedge clk);
            n++;
        end
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_code = CMD_NONE;
        cmd_arg = ~a;
    endtask

    task automatic query(input srq_cmd_t c, output logic [15:0] d);
        int n = 0;
        send(c, 16'h0000);
        while (!rsp_valid_ff && n < 4) begin
            @(negedge clk);
            n++;
        end
        d = rsp_valid_ff ? rsp_data_ff : 16'hXXXX;
    endtask

    task automatic poll(output logic [7:0] b);
        int n = 0;
        @(negedge clk);
        serial_poll = 1'b1;
        @(negedge clk);
        serial_poll = 1'b0;
        while (!poll_valid_ff && n < 3) begin
            @(negedge clk);
            n++;
        end
        b = poll_valid_ff ? poll_byte_ff : 8'hXX;
    endtask
endmodule

/* File: verification/status_reporting_srq_test.sv */
// status_reporting_srq_test: self-checking bench of the status block
// assumes srq_host as controller; strobes and levels driven at falling edge
`timescale 1ns/1ps
module status_reporting_srq_test;
    import srq_pkg::*;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ops_pending = 1'b0;
    logic        triggered_mode = 1'b0;
    logic        power_on = 1'b0;
    logic [5:0]  pulses = 6'h00;
    logic [3:0]  cond = 4'h0;
    logic [15:0] err_code = 16'h0000;
    logic        cmd_valid, cmd_ready_ff, rsp_valid_ff, serial_poll, poll_valid_ff;
    logic        srq_ff, error_ind_ff, overload_ff;
    logic [15:0] cmd_arg, rsp_data_ff, d, m, ese, qevt;
    logic [7:0]  poll_byte_ff, b;
    srq_cmd_t    cmd_code;
    logic [15:0] errq[$];
    int          n_errors = 0;
    int          samples_checked = 0;
    int          i;

    always #25 clk = ~clk;

    srq_status i_srq_status (.clk(clk), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .cmd_arg(cmd_arg), .cmd_ready_ff(cmd_ready_ff),
        .rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff), .ops_pending(ops_pending),
        .triggered_mode(triggered_mode), .obuf_push(pulses[0]), .obuf_pop(pulses[1]),
        .power_on(power_on), .constant_current_mode(cond[0]),
        .constant_voltage_mode(cond[1]), .fan_fault(cond[2]), .ov_tripped(cond[3]),
        .ev_query_err(pulses[2]), .ev_device_err(pulses[3]), .ev_exec_err(pulses[4]),
        .ev_cmd_err(pulses[5]), .err_code(err_code), .serial_poll(serial_poll),
        .poll_byte_ff(poll_byte_ff), .poll_valid_ff(poll_valid_ff), .srq_ff(srq_ff),
        .error_ind_ff(error_ind_ff), .overload_ff(overload_ff));

    srq_host i_srq_host (.clk(clk), .cmd_ready_ff(cmd_ready_ff), .rsp_valid_ff(rsp_valid_ff),
        .rsp_data_ff(rsp_data_ff), .poll_valid_ff(poll_valid_ff),
        .poll_byte_ff(poll_byte_ff), .cmd_code(cmd_code), .cmd_valid(cmd_valid),
        .cmd_arg(cmd_arg), .serial_poll(serial_poll));

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        chk_word({15'h0000, got}, {15'h0000, exp});
    endtask

    task automatic give_verdict;
        $display("compared %0d, mismatched %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic pulse(input logic [5:0] s);
        @(negedge clk);
        pulses = s;
        @(negedge clk);
        pulses = 6'h00;
    endtask

    // query, compare, then read the answer out of the buffer
    task automatic q(input srq_cmd_t c, input logic [15:0] e);
        i_srq_host.query(c, d);
        chk_word(d, e);
        pulse(6'h02);
    endtask

    task automatic pl(input logic [7:0] e);
        i_srq_host.poll(b);
        chk_word({8'h00, b}, {8'h00, e});
    endtask

    function automatic logic [15:0] qmap(input logic [3:0] c);
        return {6'h00, c[3], 4'h0, c[2], 2'h0, c[1], c[0]};
    endfunction

    initial begin
        #2000000;
        n_errors++;
        give_verdict();
    end

    initial begin
        void'($urandom(85788));
        qevt = 16'h0000;
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        q(CMD_PSC_RD, 16'h0001);
        q(CMD_ESE_RD, 16'h0000);
        q(CMD_SRE_RD, 16'h0000);
        power_on = 1'b1;
        tick(3);
        q(CMD_ESR_RD, 16'h0080);
        q(CMD_ESR_RD, 16'h0000);
        for (i = 0; i < 2; i++) begin
            ese = {8'h00, 8'($urandom) & ESR_USED_MASK};
            i_srq_host.send(CMD_ESE_WR, ese);
            q(CMD_ESE_RD, ese);
            m = {8'h00, 8'($urandom) & 8'h38};
            i_srq_host.send(CMD_SRE_WR, m);
            q(CMD_SRE_RD, m);
            m = 16'($urandom) & QUES_USED_MASK;
            i_srq_host.send(CMD_QENA_WR, m);
            q(CMD_QENA_RD, m);
        end
        for (i = 0; i < 2; i++) begin
            i_srq_host.send(CMD_PSC_WR, 16'(i));
            q(CMD_PSC_RD, 16'(i));
            power_on = 1'b0;
            tick(2);
            power_on = 1'b1;
            tick(3);
            q(CMD_ESE_RD, i ? 16'h0000 : ese);
        end
        q(CMD_SRE_RD, 16'h0000);
        for (i = 0; i < 4; i++) begin
            cond = {2'($urandom), 2'(i)};
            tick(2);
            q(CMD_QCOND_RD, qmap(cond));
            qevt = qevt | qmap(cond);
        end
        cond = 4'h0;
        q(CMD_QEVT_RD, qevt);
        q(CMD_QEVT_RD, 16'h0000);
        i_srq_host.send(CMD_CLS, 16'h0000);
        i_srq_host.send(CMD_ESE_WR, 16'h0001);
        i_srq_host.send(CMD_SRE_WR, 16'h0000);
        q(CMD_OPC_RD, OPC_ANSWER);
        i_srq_host.send(CMD_OPC, 16'h0000);
        tick(3);
        chk_bit(srq_ff, 1'b0);
        q(CMD_STB_RD, 16'h0020);
        i_srq_host.send(CMD_SRE_WR, 16'h0020);
        tick(3);
        chk_bit(srq_ff, 1'b1);
        q(CMD_STB_RD, 16'h0060);
        chk_bit(srq_ff, 1'b1);
        q(CMD_ESR_RD, 16'h0001);
        tick(2);
        chk_bit(srq_ff, 1'b0);
        i_srq_host.send(CMD_QENA_WR, 16'h0010);
        i_srq_host.send(CMD_SRE_WR, 16'h0008);
        cond = 4'h4;
        tick(2);
        cond = 4'h0;
        tick(3);
        chk_bit(srq_ff, 1'b1);
        pl(8'h48);
        chk_bit(srq_ff, 1'b0);
        pl(8'h08);
        i_srq_host.send(CMD_CLS, 16'h0000);
        q(CMD_STB_RD, 16'h0000);
        q(CMD_QEVT_RD, 16'h0000);
        pulse(6'h01);
        pl(8'h10);
        pulse(6'h01);
        pulse(6'h02);
        pl(8'h10);
        pulse(6'h02);
        pl(8'h00);
        for (i = 0; i < 21; i++) begin
            err_code = 16'($urandom);
            pulse(6'(4 << (i % 4)));
            if (errq.size() < 20)
                errq.push_back(err_code);
            else
                errq[19] = ERR_OVERFLOW;
        end
        tick(2);
        chk_bit(error_ind_ff, 1'b1);
        q(CMD_ESR_RD, 16'h003C);
        while (errq.size() > 0)
            q(CMD_ERR_RD, errq.pop_front());
        tick(2);
        chk_bit(error_ind_ff, 1'b0);
        q(CMD_ERR_RD, ERR_NONE);
        ops_pending = 1'b1;
        for (i = 0; i < 2; i++) begin
            triggered_mode = 1'(i);
            i_srq_host.send(CMD_WAI, 16'h0000);
            repeat (4) begin
                @(negedge clk);
                chk_bit(cmd_ready_ff, !triggered_mode);
            end
        end
        ops_pending = 1'b0;
        q(CMD_STB_RD, 16'h0000);
        for (i = 0; i < OBUF_LIMIT; i++)
            i_srq_host.query(CMD_PSC_RD, d);
        chk_bit(overload_ff, 1'b0);
        i_srq_host.send(CMD_PSC_RD, 16'h0000);
        tick(2);
        chk_bit(overload_ff, 1'b1);
        chk_bit(cmd_ready_ff, 1'b0);
        pulse(6'h02);
        tick(2);
        chk_bit(overload_ff, 1'b0);
        repeat (15) pulse(6'h02);
        give_verdict();
    end
endmodule

bind srq_status srq_status_checker i_srq_status_checker (.clk(clk), .rst(rst),
    .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_ready_ff(cmd_ready_ff),
    .rsp_valid_ff(rsp_valid_ff), .rsp_data_ff(rsp_data_ff), .ops_pending(ops_pending),
    .triggered_mode(triggered_mode), .serial_poll(serial_poll),
    .poll_byte_ff(poll_byte_ff), .poll_valid_ff(poll_valid_ff), .srq_ff(srq_ff),
    .overload_ff(overload_ff));
